// ---- verilog/channel_input_range_select.sv ----
/*
 * APB register bank holding the input span codes of channels 3 to 8,
 * with each code and its decoded span class driven out per channel.
 * Assumes an APB master on mclk and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module channel_input_range_select (
    // Clock and reset
    input  wire logic                                        mclk,
    input  wire logic                                        resetn,
    // APB slave
    input  wire logic                                        psel,
    input  wire logic                                        penable,
    input  wire logic                                        pwrite,
    input  wire logic [range_sel_pkg::ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                                 pwdata,
    input  wire logic [3:0]                                  pstrb,
    output logic                                             pready,
    output logic                                             pslverr,
    output logic [31:0]                                      prdata,
    // Per-channel span selection, index 0 is channel 3
    output range_sel_pkg::chan_span_type [range_sel_pkg::NUM_CH-1:0] input_span_sel
);
    import range_sel_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PAIRS-1:0][7:0]        pairs;
        chan_span_type [NUM_CH-1:0]       span;
        logic                             pready;
        logic                             pslverr;
        logic [31:0]                      prdata;
    } state_type;

    function automatic span_class_type span_class(input logic [SPAN_W-1:0] code);
        if (code <= CODE_BIP_SE_LAST) begin
            return SPAN_BIPOLAR_SE;
        end else if (code <= CODE_UNI_SE_LAST) begin
            return SPAN_UNIPOLAR_SE;
        end else if (code <= CODE_BIP_DF_LAST) begin
            return SPAN_BIPOLAR_DIFF;
        end else begin
            return SPAN_RESERVED;
        end
    endfunction

    function automatic logic [NUM_PAIRS-1:0] pair_hit(input logic [ADDR_W-1:0] a);
        logic [NUM_PAIRS-1:0] hit;
        hit = '0;
        for (int k = 0; k < NUM_PAIRS; k++) begin
            hit[k] = (a == PAIR_ADDR[k]);
        end
        return hit;
    endfunction

    localparam chan_span_type SPAN_RST = '{code: SPAN_CODE_RST, cls: SPAN_BIPOLAR_SE};
    localparam state_type     ST_RST   = '{
        pairs:   {NUM_PAIRS{RANGE_PAIR_RST}},
        span:    {NUM_CH{SPAN_RST}},
        pready:  1'b0,
        pslverr: 1'b0,
        prdata:  RDATA_RST
    };

    state_type            st_ff;
    state_type            nxt_st;
    logic [NUM_PAIRS-1:0] hit;
    logic                 access;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // One wait state: the answer is registered so every output comes from a flop.
    always_comb begin
        nxt_st = st_ff;
        access = psel & penable;
        hit    = pair_hit(paddr);
        if (access && !st_ff.pready) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = ~(|hit);
            nxt_st.prdata  = RDATA_RST;
            for (int k = 0; k < NUM_PAIRS; k++) begin
                if (hit[k]) begin
                    nxt_st.prdata = {24'h00_0000, st_ff.pairs[k]};
                end
            end
        end else begin
            nxt_st.pready  = 1'b0;
            nxt_st.pslverr = 1'b0;
            if (access && pwrite && pstrb[0]) begin
                for (int k = 0; k < NUM_PAIRS; k++) begin
                    if (hit[k]) begin
                        nxt_st.pairs[k] = pwdata[7:0];
                    end
                end
            end
        end
        // Span outputs follow the new pair value, so they change with it.
        for (int i = 0; i < NUM_CH; i++) begin
            nxt_st.span[i].code = nxt_st.pairs[i/2][(i%2)*SPAN_W +: SPAN_W];
            nxt_st.span[i].cls  = span_class(nxt_st.span[i].code);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pready         = st_ff.pready;
    assign pslverr        = st_ff.pslverr;
    assign prdata         = st_ff.prdata;
    assign input_span_sel = st_ff.span;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    logic wr_done;
    assign wr_done = psel && penable && st_ff.pready && pwrite && pstrb[0];

    AST_PAIR56_WRITE: assert property (
        wr_done && paddr == ADDR_RANGE_56 |=> st_ff.pairs[1] == $past(pwdata[7:0])
    ) else $error("Channel 5/6 pair did not take the written value");

    AST_PAIR78_WRITE: assert property (
        wr_done && paddr == ADDR_RANGE_78 |=> st_ff.pairs[2] == $past(pwdata[7:0])
    ) else $error("Channel 7/8 pair did not take the written value");

    AST_PAIR34_WRITE: assert property (
        wr_done && paddr == ADDR_RANGE_34 |=> st_ff.pairs[0] == $past(pwdata[7:0])
    ) else $error("Channel 3/4 pair did not take the written value");

    AST_PAIR34_FIELDS: assert property (
        input_span_sel[1].code == st_ff.pairs[0][HI_SPAN_LSB +: SPAN_W]
        && input_span_sel[0].code == st_ff.pairs[0][LO_SPAN_LSB +: SPAN_W]
    ) else $error("Channel 3/4 span fields misplaced");

    AST_PAIR56_FIELDS: assert property (
        input_span_sel[3].code == st_ff.pairs[1][HI_SPAN_LSB +: SPAN_W]
        && input_span_sel[2].code == st_ff.pairs[1][LO_SPAN_LSB +: SPAN_W]
    ) else $error("Channel 5/6 span fields misplaced");

    AST_PAIR78_FIELDS: assert property (
        input_span_sel[5].code == st_ff.pairs[2][HI_SPAN_LSB +: SPAN_W]
        && input_span_sel[4].code == st_ff.pairs[2][LO_SPAN_LSB +: SPAN_W]
    ) else $error("Channel 7/8 span fields misplaced");

    AST_CLASS_BIPOLAR_SE: assert property (
        input_span_sel[0].code <= 4'h4 |-> input_span_sel[0].cls == SPAN_BIPOLAR_SE
    ) else $error("Bipolar single-ended code decoded wrongly");

    AST_CLASS_UNIPOLAR: assert property (
        input_span_sel[2].code inside {[4'h5:4'h7]}
        |-> input_span_sel[2].cls == SPAN_UNIPOLAR_SE
    ) else $error("Unipolar code decoded wrongly");

    AST_CLASS_DIFF: assert property (
        input_span_sel[5].code inside {[4'h8:4'hb]}
        |-> input_span_sel[5].cls == SPAN_BIPOLAR_DIFF
    ) else $error("Differential code decoded wrongly");

    AST_READBACK: assert property (
        psel && penable && !st_ff.pready && !pwrite && paddr == ADDR_RANGE_78
        |=> pready && prdata == {24'h00_0000, st_ff.pairs[2]}
    ) else $error("Read of channel 7/8 pair returned the wrong value");

    AST_WRITE_ISOLATED: assert property (
        wr_done && paddr == ADDR_RANGE_56
        |=> $stable(st_ff.pairs[0]) && $stable(st_ff.pairs[2])
    ) else $error("Write to one pair disturbed another");

endmodule

// ---- verilog/range_sel_pkg.sv ----
/*
 * Constants and types for the per-channel input span selection bank
 * (channels 3 to 8).
 * Assumes a 32-bit APB register bus. Each printed register offset is a
 * word index, so the byte address is four times that index.
 */
package range_sel_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          NUM_PAIRS      = 3;
    localparam int          NUM_CH         = 6;
    localparam int          ADDR_W         = 12;
    localparam logic [7:0]  IDX_RANGE_34   = 8'h04;
    localparam logic [7:0]  IDX_RANGE_56   = 8'h05;
    localparam logic [7:0]  IDX_RANGE_78   = 8'h06;
    localparam logic [11:0] ADDR_RANGE_34  = {2'b00, IDX_RANGE_34, 2'b00};
    localparam logic [11:0] ADDR_RANGE_56  = {2'b00, IDX_RANGE_56, 2'b00};
    localparam logic [11:0] ADDR_RANGE_78  = {2'b00, IDX_RANGE_78, 2'b00};
    localparam logic [NUM_PAIRS-1:0][11:0] PAIR_ADDR =
        {ADDR_RANGE_78, ADDR_RANGE_56, ADDR_RANGE_34};

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          SPAN_W         = 4;
    localparam int          LO_SPAN_LSB    = 0;
    localparam int          HI_SPAN_LSB    = 4;
    localparam logic [7:0]  RANGE_PAIR_RST = 8'h33;
    localparam logic [3:0]  SPAN_CODE_RST  = 4'h3;
    localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

    // ------------------------------------------------------------
    // Span code groups
    // ------------------------------------------------------------
    localparam logic [3:0]  CODE_BIP_SE_LAST = 4'h4;
    localparam logic [3:0]  CODE_UNI_SE_LAST = 4'h7;
    localparam logic [3:0]  CODE_BIP_DF_LAST = 4'hb;

    typedef enum logic [1:0] {
        SPAN_BIPOLAR_SE   = 2'h0,
        SPAN_UNIPOLAR_SE  = 2'h1,
        SPAN_BIPOLAR_DIFF = 2'h2,
        SPAN_RESERVED     = 2'h3
    } span_class_type;

    typedef struct packed {
        logic [SPAN_W-1:0] code;
        span_class_type    cls;
    } chan_span_type;

endpackage

// ---- bench/channel_input_range_select_tb.sv ----
/*
 * Self-checking bench for the channel 3 to 8 span selection bank.
 * Assumes the bank answers APB with pready and that assertions sit in the design.
 */
`timescale 1ns/1ps

module channel_input_range_select_tb;
    import range_sel_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic                        mclk = 1'b0;
    logic                        resetn = 1'b0;
    logic                        psel = 1'b0;
    logic                        penable = 1'b0;
    logic                        pwrite = 1'b0;
    logic [ADDR_W-1:0]           paddr = 12'h000;
    logic [31:0]                 pwdata = 32'h0000_0000;
    logic [3:0]                  pstrb = 4'h0;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
    chan_span_type [NUM_CH-1:0]  input_span_sel;
    int                          n_fail = 0;
    int                          n_checks = 0;
    logic [31:0]                 rd;
    logic                        er;

    always #5 mclk = ~mclk;

    channel_input_range_select dut (
        .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .input_span_sel(input_span_sel)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Request held until pready is sampled high; a stuck slave ends the run
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge mclk);
    endtask

    function automatic logic [1:0] cls_of(input logic [3:0] c);
        if (c <= 4'h4) return 2'h0;
        if (c <= 4'h7) return 2'h1;
        if (c <= 4'hb) return 2'h2;
        return 2'h3;
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int i = 0; i < NUM_PAIRS; i++) begin
            apb(1'b0, PAIR_ADDR[i], 32'h0000_0000, 4'h0);
            chk("reset pair", 32'h0000_0033, rd);
            chk("reset err", 32'h0000_0000, 32'(er));
        end
        for (int i = 0; i < NUM_CH; i++) begin
            chk("reset code", 32'h0000_0003, 32'(input_span_sel[i].code));
            chk("reset class", 32'h0000_0000, 32'(input_span_sel[i].cls));
        end
        $display("test reset done");
    endtask

    // Every defined code in both nibbles of the 5/6 pair; reserved codes stay unwritten
    task automatic t_codes();
        logic [3:0] c;
        logic [3:0] m;
        for (int k = 0; k < 12; k++) begin
            c = 4'(k);
            m = 4'hb - c;
            apb(1'b1, ADDR_RANGE_56, {24'h00_0000, c, m}, 4'h1);
            chk("ch6 code", 32'(c), 32'(input_span_sel[3].code));
            chk("ch5 code", 32'(m), 32'(input_span_sel[2].code));
            chk("ch6 class", 32'(cls_of(c)), 32'(input_span_sel[3].cls));
            chk("ch5 class", 32'(cls_of(m)), 32'(input_span_sel[2].cls));
        end
        $display("test codes done");
    endtask

    task automatic t_indep();
        logic [7:0] v[3] = '{8'h5a, 8'h0b, 8'h71};
        for (int i = 0; i < NUM_PAIRS; i++)
            apb(1'b1, PAIR_ADDR[i], {24'h00_0000, v[i]}, 4'h1);
        for (int i = 0; i < NUM_PAIRS; i++) begin
            apb(1'b0, PAIR_ADDR[i], 32'h0000_0000, 4'h0);
            chk("readback", {24'h00_0000, v[i]}, rd);
            chk("lo field", 32'(v[i][3:0]), 32'(input_span_sel[2*i].code));
            chk("hi field", 32'(v[i][7:4]), 32'(input_span_sel[2*i+1].code));
        end
        $display("test independence done");
    endtask

    // Unmapped and unaligned places answer with an error and change nothing
    task automatic t_refuse();
        apb(1'b1, 12'h01c, 32'h0000_00ff, 4'h1);
        chk("unmapped wr err", 32'h0000_0001, 32'(er));
        apb(1'b0, 12'h015, 32'h0000_0000, 4'h0);
        chk("unaligned rd err", 32'h0000_0001, 32'(er));
        chk("unaligned rd data", 32'h0000_0000, rd);
        apb(1'b1, ADDR_RANGE_56, 32'h0000_00ee, 4'h0);
        chk("no strobe err", 32'h0000_0000, 32'(er));
        apb(1'b0, ADDR_RANGE_56, 32'h0000_0000, 4'h0);
        chk("no strobe keep", 32'h0000_000b, rd);
        $display("test refusal done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_codes();
        t_indep();
        t_refuse();
        end_sim();
    end
endmodule
